// ==== inc/spc_defines.vh ====
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define SPC_CLK_PERIOD_PS     4000
// times in microseconds, as printed defaults of our own
`define SPC_GRACE_US          1000
`define SPC_RELDLY_US         2000
`define SPC_STUCK_US          500
`define SPC_US_TO_CYC(us)     ((us) * 1000000 / `SPC_CLK_PERIOD_PS)
`define SPC_GRACE_CYC         `SPC_US_TO_CYC(`SPC_GRACE_US)
`define SPC_RELDLY_CYC        `SPC_US_TO_CYC(`SPC_RELDLY_US)
`define SPC_STUCK_CYC         `SPC_US_TO_CYC(`SPC_STUCK_US)
`define SPC_TMR_W             24

// ---------------------------------------------------------------
// register map (word offsets are byte addresses)
// ---------------------------------------------------------------
`define SPC_ADDR_W            4
`define SPC_REG_CTRL          4'h0
`define SPC_REG_OVR           4'h4
`define SPC_REG_STAT          4'h8

// ctrl fields
`define SPC_CTRL_HOLD         0
// override fields, one per wake source
`define SPC_OVR_LIN           0
`define SPC_OVR_STATUS        1
`define SPC_OVR_SWITCH        2
`define SPC_OVR_NET           3
`define SPC_NSRC              4

// status fields
`define SPC_STAT_ACTIVE       0
`define SPC_STAT_ACTV         1
`define SPC_STAT_HOLDOK       2
`define SPC_STAT_RSTOK        3
`define SPC_STAT_MINOK        4

`define SPC_CTRL_RST          8'h00
`define SPC_OVR_RST           8'h00

`endif

// ==== hdl/spc_timer.v ====
`timescale 1ns/1ps
`include "spc_defines.vh"

// restartable up-counter, done once count reaches terminal
module spc_timer #(
  parameter W = `SPC_TMR_W
) (
  input  wire         ref_clk,   // clock
  input  wire         rst_n,     // async reset
  input  wire         restart,   // clear and count again
  input  wire         preset,    // force done
  input  wire [W-1:0] termCnt,   // terminal count
  output wire         done       // count reached
);

  reg [W-1:0] cnt_q;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
    end else if (restart) begin
      cnt_q <= {W{1'b0}};
    end else if (preset) begin
      cnt_q <= termCnt;
    end else if (cnt_q != termCnt) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = (cnt_q == termCnt);

endmodule

// ==== hdl/spc_sleep_ctrl.v ====
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "spc_defines.vh"

module spc_sleep_ctrl #(
  parameter GRACE_CYC  = `SPC_GRACE_CYC,   // grace time in cycles
  parameter RELDLY_CYC = `SPC_RELDLY_CYC,  // release delay in cycles
  parameter STUCK_CYC  = `SPC_STUCK_CYC    // stuck-reset time in cycles
) (
  input  wire                   ref_clk,              // always-on clock
  input  wire                   rst_n,                // async reset, low
  input  wire                   wakeQualified,        // qualified wake event pulse/level
  input  wire                   wakeInRange,          // supply in allowed wake range
  input  wire                   lowSupplyRegion,      // supply in low region
  input  wire                   switchedSupplyValid,  // switched supply valid
  input  wire                   linWake_n,            // lin activity, low active
  input  wire                   statusWake_n,         // status activity, low active
  input  wire                   localSwitchWake_n,    // local switch, low active
  input  wire                   electricalNetActivity,// net activity, high active
  input  wire                   powerHold_n,          // hold pin, low keeps active while switched supply valid
  input  wire                   resetPin_n,           // reset pin level
  input  wire [`SPC_ADDR_W-1:0] regAddr,              // register address
  input  wire [7:0]             regWdata,             // write data
  input  wire                   regWr,                // write strobe
  input  wire                   regRd,                // read strobe
  output reg  [7:0]             regRdata,             // read data, cycle after strobe
  output wire                   regEnableOut,         // regulator enable drive level
  output wire                   regEnableOe,          // regulator enable output enable
  output wire                   activeMode            // device is active
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [1:0] ST_ACTIVE = 2'b01;
  localparam [1:0] ST_SLEEP  = 2'b10;

  localparam [`SPC_TMR_W-1:0] GRACE_T  = GRACE_CYC;
  localparam [`SPC_TMR_W-1:0] RELDLY_T = RELDLY_CYC;
  localparam [`SPC_TMR_W-1:0] STUCK_T  = STUCK_CYC;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam NSYNC = 10;
  wire [NSYNC-1:0] pinRaw = {switchedSupplyValid, lowSupplyRegion, wakeInRange, wakeQualified,
                             resetPin_n, powerHold_n, electricalNetActivity,
                             localSwitchWake_n, statusWake_n, linWake_n};
  reg  [NSYNC-1:0] syncA_q;
  reg  [NSYNC-1:0] syncB_q;

  // all pins idle-high except activity, qualifiers and low region; reset to inactive values
  localparam [NSYNC-1:0] SYNC_RST = 10'h237;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= SYNC_RST;
      syncB_q <= SYNC_RST;
    end else begin
      syncA_q <= pinRaw;
      syncB_q <= syncA_q;
    end
  end

  wire [`SPC_NSRC-1:0] srcActive;
  assign srcActive[`SPC_OVR_LIN]    = ~syncB_q[0];
  assign srcActive[`SPC_OVR_STATUS] = ~syncB_q[1];
  assign srcActive[`SPC_OVR_SWITCH] = ~syncB_q[2];
  assign srcActive[`SPC_OVR_NET]    =  syncB_q[3];
  wire holdPinLow  = ~syncB_q[4];
  wire rstPin      =  syncB_q[5];
  wire wakeQ       =  syncB_q[6];
  wire inRange     =  syncB_q[7];
  wire lowRegion   =  syncB_q[8];
  wire supplyValid =  syncB_q[9];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg                  swHold_q;
  reg [`SPC_NSRC-1:0]  ovr_q;
  reg [1:0]            state_q;
  reg [1:0]            state_d;
  reg                  rstPinPrev_q;

  function isAddr;
    input [`SPC_ADDR_W-1:0] a;
    input [`SPC_ADDR_W-1:0] b;
    begin
      isAddr = (a == b);
    end
  endfunction

  wire wrCtrl = regWr && isAddr(regAddr, `SPC_REG_CTRL);
  wire wrOvr  = regWr && isAddr(regAddr, `SPC_REG_OVR);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      swHold_q <= 1'b0;
    end else if (wrCtrl) begin
      swHold_q <= regWdata[`SPC_CTRL_HOLD];
    end
  end

  // override bits; recovery of the masked input wins over a write
  genvar g;
  generate
    for (g = 0; g < `SPC_NSRC; g = g + 1) begin : gOvr
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          ovr_q[g] <= 1'b0;
        end else if (ovr_q[g] && !srcActive[g]) begin
          ovr_q[g] <= 1'b0;
        end else if (wrOvr) begin
          ovr_q[g] <= regWdata[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // sleep conditions
  // ---------------------------------------------------------------
  wire activity   = |(srcActive & ~ovr_q);
  wire noActivity = ~activity | lowRegion;

  // software hold acts as a low hold pin; invalid supply ignores both
  wire holdAsserted = (holdPinLow | swHold_q) & supplyValid;
  wire isActive     = (state_q == ST_ACTIVE);
  wire enterActive  = !isActive && wakeQ && inRange;

  wire graceDone;
  wire relDone;
  wire rstFallDone;
  wire rstRiseDone;
  wire minActDone;

  // grace restarts on entry; a hold ends the grace wait, so that
  // after release only the release delay gates sleep
  spc_timer uGrace (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .restart (enterActive),
    .preset  (holdAsserted),
    .termCnt (GRACE_T),
    .done    (graceDone)
  );

  // release delay, skipped in the low region
  spc_timer uRelDly (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .restart (holdAsserted),
    .preset  (lowRegion),
    .termCnt (RELDLY_T),
    .done    (relDone)
  );

  wire rstFall = rstPinPrev_q & ~rstPin;
  wire rstRise = ~rstPinPrev_q & rstPin;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPinPrev_q <= 1'b1;
    end else begin
      rstPinPrev_q <= rstPin;
    end
  end

  spc_timer uRstFall (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .restart (rstFall),
    .preset  (1'b0),
    .termCnt (STUCK_T),
    .done    (rstFallDone)
  );

  spc_timer uRstRise (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .restart (rstRise),
    .preset  (1'b0),
    .termCnt (GRACE_T),
    .done    (rstRiseDone)
  );

  // minimum active time counted from enable going low
  spc_timer uMinAct (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .restart (enterActive),
    .preset  (1'b0),
    .termCnt (GRACE_T),
    .done    (minActDone)
  );

  // while reset is low only the stuck timer gates resetOk; holdOk is
  // still required, so a hold keeps the device active despite a stuck pin
  wire resetOk = rstPin ? rstRiseDone : rstFallDone;
  wire holdOk  = !holdAsserted && relDone && graceDone;

  wire sleepOk = noActivity && holdOk && resetOk && minActDone;

  // ---------------------------------------------------------------
  // state machine; reset leaves the device active
  // ---------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_ACTIVE: begin
        if (sleepOk) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (enterActive) begin
          state_d = ST_ACTIVE;
        end
      end
      default: begin
        state_d = ST_ACTIVE;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // enable is open drain: driven low when active, floated in sleep
  assign regEnableOut = 1'b0;
  assign regEnableOe  = isActive;
  assign activeMode   = isActive;

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  wire [7:0] statWord = {3'h0, minActDone, resetOk, holdOk, activity, isActive};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      if (isAddr(regAddr, `SPC_REG_CTRL)) begin
        regRdata <= {7'h00, swHold_q};
      end else if (isAddr(regAddr, `SPC_REG_OVR)) begin
        regRdata <= {4'h0, ovr_q};
      end else if (isAddr(regAddr, `SPC_REG_STAT)) begin
        regRdata <= statWord;
      end else begin
        regRdata <= 8'h00;
      end
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule

// ==== testbench/spc_sleep_ctrl_sva.sv ====
`timescale 1ns/1ps
module spc_sleep_ctrl_sva #(
  parameter GRACE_CYC = 20,
  parameter STUCK_CYC = 10
) (
  input wire ref_clk,               // clock
  input wire rst_n,                 // reset
  input wire wakeQualified,         // wake
  input wire wakeInRange,           // range
  input wire lowSupplyRegion,       // low
  input wire switchedSupplyValid,   // supply
  input wire localSwitchWake_n,     // switch
  input wire electricalNetActivity, // net
  input wire powerHold_n,           // hold
  input wire resetPin_n,            // pin
  input wire regEnableOut,          // level
  input wire regEnableOe,           // enable
  input wire activeMode             // state
);
  reg [15:0] actCnt_q;
  reg [15:0] edgeCnt_q;
  reg        pin_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // edge counter saturates so long quiet spells stay legal
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      actCnt_q <= 16'h0000;
      edgeCnt_q <= 16'h0000;
      pin_q <= 1'b1;
    end else begin
      actCnt_q <= activeMode ? actCnt_q + 16'h0001 : 16'h0000;
      edgeCnt_q <= (pin_q != resetPin_n) ? 16'h0000 : edgeCnt_q + {15'h0000, ~&edgeCnt_q};
      pin_q <= resetPin_n;
    end
  end
  chk_active_drive: assert property (activeMode |-> regEnableOe && !regEnableOut)
    else $error("enable not driven low while active");
  chk_sleep_release: assert property (!activeMode |-> !regEnableOe)
    else $error("enable driven while asleep");
  chk_wake_enter: assert property (!activeMode && wakeQualified && wakeInRange |-> ##[1:4] activeMode)
    else $error("qualified wake not taken");
  chk_wake_cause: assert property ($rose(activeMode) |-> $past(wakeQualified, 3) && $past(wakeInRange, 3))
    else $error("woke without qualified wake");
  chk_min_active: assert property ($fell(activeMode) |-> actCnt_q >= GRACE_CYC - 1)
    else $error("active time too short");
  chk_stuck_time: assert property ($fell(activeMode) && !resetPin_n |-> edgeCnt_q >= STUCK_CYC)
    else $error("slept too soon after pin fall");
  chk_rise_grace: assert property ($fell(activeMode) && resetPin_n |-> edgeCnt_q >= GRACE_CYC)
    else $error("slept too soon after pin rise");
  chk_hold_keeps: assert property ($fell(activeMode) |->
    $past(powerHold_n, 3) || !$past(switchedSupplyValid, 3)) else $error("slept while held");
  chk_activity_keeps: assert property ($fell(activeMode) |-> $past(lowSupplyRegion, 3) ||
    ($past(localSwitchWake_n, 3) && !$past(electricalNetActivity, 3))) else $error("slept during activity");
endmodule

// ==== testbench/spc_host_model.sv ====
`timescale 1ns/1ps
module spc_host_model (
  input  wire ref_clk,    // clock
  input  wire rst_n,      // reset
  input  wire keepOn,     // wants power
  input  wire resetPin_n, // reset pin
  output reg  powerHold_n // hold, pulled up
);
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerHold_n <= 1'b1;
    end else begin
      powerHold_n <= ~(keepOn & resetPin_n);
    end
  end
endmodule

// ==== testbench/spc_sleep_ctrl_tb.sv ====
`timescale 1ns/1ps
module spc_sleep_ctrl_tb;
  localparam GR = 20;
  localparam RD = 30;
  localparam ST = 10;
  reg        ref_clk, rst_n, wakeQ, wakeR, lowReg, supOk, linN, netAct, keepOn, rstPinN, regWr, regRd;
  reg  [3:0] regAddr;
  reg  [7:0] regWdata;
  wire [7:0] regRdata;
  wire       enOut, enOe, actMode, holdN;
  integer    n_mismatch, checks_done;
  spc_sleep_ctrl #(.GRACE_CYC(GR), .RELDLY_CYC(RD), .STUCK_CYC(ST)) spc_sleep_ctrl_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .wakeQualified(wakeQ), .wakeInRange(wakeR),
    .lowSupplyRegion(lowReg), .switchedSupplyValid(supOk), .linWake_n(linN), .statusWake_n(1'b1),
    .localSwitchWake_n(1'b1), .electricalNetActivity(netAct), .powerHold_n(holdN), .resetPin_n(rstPinN),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .regEnableOut(enOut), .regEnableOe(enOe), .activeMode(actMode));
  spc_host_model spc_host_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .keepOn(keepOn),
    .resetPin_n(rstPinN), .powerHold_n(holdN));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task print_verdict;
    begin
      if (n_mismatch == 0 && checks_done > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  task check(input [63:0] nm, input [7:0] ex, input [7:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== ex) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL %0s exp %h got %h", nm, ex, got);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // bounded wait; a timeout ends the run
  task expAct(input e, input integer lim);
    integer i;
    begin
      i = 0;
      #1;
      while (actMode !== e && i < lim) begin
        @(posedge ref_clk);
        #1;
        i = i + 1;
      end
      check("actMode", {7'h00, e}, {7'h00, actMode});
      if (actMode !== e) print_verdict;
      @(posedge ref_clk);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] ex);
    begin
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 check("regRdata", ex, regRdata);
      @(posedge ref_clk);
    end
  endtask
  task wake;
    begin
      wakeQ <= 1'b1;
      expAct(1'b1, 8);
      wakeQ <= 1'b0;
    end
  endtask
  initial begin
    {rst_n, wakeQ, lowReg, netAct, keepOn, regWr, regRd} = 7'h00;
    {wakeR, supOk, linN, rstPinN} = 4'hF;
    regAddr = 4'h0;
    regWdata = 8'h00;
    n_mismatch = 0;
    checks_done = 0;
    tick(5);
    rst_n <= 1'b1;
    expAct(1'b1, 0);
    check("enOut", 8'h00, {7'h00, enOut});
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'hC, 8'h00);
    tick(GR - 10);
    expAct(1'b1, 0);
    expAct(1'b0, 40);
    // wake refused out of range
    wakeR <= 1'b0;
    wakeQ <= 1'b1;
    tick(10);
    expAct(1'b0, 0);
    wakeR <= 1'b1;
    wake;
    keepOn <= 1'b1;
    tick(200);
    expAct(1'b1, 0);
    wr(4'h0, 8'h01);
    keepOn <= 1'b0;
    tick(100);
    expAct(1'b1, 0);
    rd(4'h0, 8'h01);
    wr(4'h0, 8'h00);
    tick(RD - 8);
    expAct(1'b1, 0);
    expAct(1'b0, 20);
    // stuck lin masked, then recovers
    wake;
    linN <= 1'b0;
    tick(100);
    expAct(1'b1, 0);
    wr(4'h4, 8'h01);
    expAct(1'b0, 60);
    rd(4'h4, 8'h01);
    linN <= 1'b1;
    tick(5);
    rd(4'h4, 8'h00);
    // low region skips delay, ignores activity
    wake;
    keepOn <= 1'b1;
    tick(40);
    lowReg <= 1'b1;
    netAct <= 1'b1;
    keepOn <= 1'b0;
    expAct(1'b0, 8);
    lowReg <= 1'b0;
    netAct <= 1'b0;
    wake;
    keepOn <= 1'b1;
    tick(40);
    rstPinN <= 1'b0;
    tick(ST - 2);
    expAct(1'b1, 0);
    expAct(1'b0, 60);
    rstPinN <= 1'b1;
    wake;
    tick(40);
    supOk <= 1'b0;
    expAct(1'b0, 60);
    print_verdict;
  end
endmodule
bind spc_sleep_ctrl spc_sleep_ctrl_sva #(.GRACE_CYC(GRACE_CYC), .STUCK_CYC(STUCK_CYC)) spc_sleep_ctrl_sva_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .wakeQualified(wakeQualified), .wakeInRange(wakeInRange),
  .lowSupplyRegion(lowSupplyRegion), .switchedSupplyValid(switchedSupplyValid),
  .localSwitchWake_n(localSwitchWake_n), .electricalNetActivity(electricalNetActivity),
  .powerHold_n(powerHold_n), .resetPin_n(resetPin_n), .regEnableOut(regEnableOut),
  .regEnableOe(regEnableOe), .activeMode(activeMode));
